// >>> verilog/tmsl_pkg.sv
// Package of constants for the torque-mode speed limiter
`default_nettype none
package tmsl_pkg;
    // ------------------------------------------------------------
    // Widths and setting ranges
    // ------------------------------------------------------------
    localparam int SPD_W = 16;
    localparam int VOLT_W = 16;
    localparam logic [15:0] SET_MIN = 16'h0000;
    localparam logic [15:0] SET_MAX = 16'h2710;
    localparam logic [15:0] SET_DEFAULT = 16'h2710;
    localparam logic [15:0] GAIN_MIN = 16'h0096;
    localparam logic [15:0] GAIN_MAX = 16'h0BB8;
    localparam logic [15:0] GAIN_DEFAULT = 16'h0258;
    // ------------------------------------------------------------
    // Interrupt event bit positions
    // ------------------------------------------------------------
    localparam int EV_ON = 0;
    localparam int EV_OFF = 1;
    localparam int EV_N = 2;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ROT = 4'h1;
    localparam logic [3:0] REG_LIN = 4'h2;
    localparam logic [3:0] REG_GAIN = 4'h3;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_MASK = 4'h5;
    localparam logic [3:0] REG_LIMIT = 4'h6;
    localparam logic [3:0] REG_ACTIVE = 4'h7;
    // Control register bit positions
    localparam int CTRL_EXT = 0;
    localparam int CTRL_OVS = 1;
    localparam int CTRL_LINEAR = 2;
    localparam int CTRL_RESTART = 3;
    // ------------------------------------------------------------
    // Divider state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {TMSL_IDLE, TMSL_RUN, TMSL_DONE} tmsl_div_t;
endpackage : tmsl_pkg
`default_nettype wire

// >>> verilog/tmsl_scaler.sv
// Sequential divider: magnitude * rated / gain
`default_nettype none
module tmsl_scaler
    import tmsl_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [W-1:0] mag,
    input wire logic [W-1:0] rated,
    input wire logic [W-1:0] gain,
    output logic [W-1:0] quot,
    output logic done
);
    typedef struct packed {
        tmsl_div_t st;
        logic [2*W-1:0] num;
        logic [2*W-1:0] rem;
        logic [2*W-1:0] q;
        logic [W-1:0] den;
        logic [5:0] cnt;
        logic [W-1:0] quot;
        logic done;
    } tmsl_sc_t;
    tmsl_sc_t s, next_s;
    logic [2*W:0] trial;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        trial = '0;
        case (s.st)
            TMSL_IDLE: begin
                if (start) begin
                    next_s.num = mag * rated;
                    next_s.rem = '0;
                    next_s.q = '0;
                    next_s.den = gain;
                    next_s.cnt = 6'(2 * W);
                    next_s.st = TMSL_RUN;
                end
            end
            TMSL_RUN: begin
                trial = {s.rem, s.num[2*W-1]} - {{(W+1){1'b0}}, s.den};
                next_s.num = {s.num[2*W-2:0], 1'b0};
                if (!trial[2*W]) begin
                    next_s.rem = trial[2*W-1:0];
                    next_s.q = {s.q[2*W-2:0], 1'b1};
                end else begin
                    next_s.rem = {s.rem[2*W-2:0], s.num[2*W-1]};
                    next_s.q = {s.q[2*W-2:0], 1'b0};
                end
                next_s.cnt = s.cnt - 6'h01;
                if (s.cnt == 6'h01) begin
                    next_s.st = TMSL_DONE;
                end
            end
            TMSL_DONE: begin
                // Saturate to the output width
                next_s.quot = (|s.q[2*W-1:W]) ? '1 : s.q[W-1:0];
                next_s.done = 1'b1;
                next_s.st = TMSL_IDLE;
            end
            default: begin
                next_s.st = TMSL_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign quot = s.quot;
    assign done = s.done;
endmodule // tmsl_scaler
`default_nettype wire

// >>> verilog/tmsl_limiter.sv
// Torque-mode speed limiter top with register port and interrupt
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`default_nettype none
module tmsl_limiter
    import tmsl_pkg::*;
#(
    parameter int W = SPD_W,
    parameter logic [15:0] ROT_DEFAULT = SET_DEFAULT,
    parameter logic [15:0] LIN_DEFAULT = SET_DEFAULT,
    parameter logic [15:0] GAIN_DEF = GAIN_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [W-1:0] motor_max_speed,
    input wire logic [W-1:0] overspeed_speed,
    input wire logic [W-1:0] rated_speed,
    input wire logic [VOLT_W-1:0] vref_in,
    input wire logic signed [W:0] speed_cmd,
    input wire logic signed [W:0] motor_speed,
    input wire logic speed_limit_pin_alloc,
    output logic signed [W:0] speed_cmd_limited,
    output logic [W-1:0] speed_limit,
    output logic speed_limit_active_output,
    output logic irq
);
    typedef struct packed {
        logic torque_control_option;
        logic speed_limit_source_select;
        logic linear_motor;
        logic pend_ext;
        logic pend_ovs;
        logic pend_lin;
        logic [15:0] rotary_torque_speed_limit;
        logic [15:0] linear_force_speed_limit;
        logic [15:0] speed_reference_input_gain;
        logic [W-1:0] ext_limit;
        logic [W-1:0] limit;
        logic signed [W:0] cmd_out;
        logic active;
        logic [EV_N-1:0] status;
        logic [EV_N-1:0] mask;
        logic [31:0] rdata;
        logic irq;
        logic sc_start;
    } tmsl_state_t;

    tmsl_state_t r, next_r;
    logic [W-1:0] vmag;
    logic [W-1:0] sc_quot;
    logic sc_done;
    logic [W-1:0] setting;
    logic [W-1:0] ceiling;
    logic [W-1:0] internal_lim;
    logic [W-1:0] final_lim;
    logic [W-1:0] cmd_mag;
    logic [W-1:0] spd_mag;
    logic signed [W:0] lim_s;

    assign vmag = vref_in[VOLT_W-1] ? W'(-vref_in) : W'(vref_in);

    // Magnitude times rated speed over gain
    tmsl_scaler #(.W(W)) u_scaler (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(r.sc_start),
        .mag(vmag),
        .rated(rated_speed),
        .gain(r.speed_reference_input_gain),
        .quot(sc_quot),
        .done(sc_done)
    );

    always_comb begin
        next_r = r;
        next_r.sc_start = ~r.sc_start;
        setting = r.linear_motor ? r.linear_force_speed_limit
                                 : r.rotary_torque_speed_limit;
        ceiling = r.speed_limit_source_select ? overspeed_speed
                                              : motor_max_speed;
        internal_lim = (setting > ceiling) ? ceiling : setting;
        if (sc_done) begin
            next_r.ext_limit = sc_quot;
        end
        final_lim = internal_lim;
        if (r.torque_control_option && r.ext_limit < internal_lim) begin
            final_lim = r.ext_limit;
        end
        next_r.limit = final_lim;
        cmd_mag = speed_cmd[W] ? W'(-speed_cmd) : W'(speed_cmd);
        lim_s = {1'b0, r.limit};
        if (cmd_mag > r.limit) begin
            next_r.cmd_out = speed_cmd[W] ? -lim_s : lim_s;
        end else begin
            next_r.cmd_out = speed_cmd;
        end
        spd_mag = motor_speed[W] ? W'(-motor_speed) : W'(motor_speed);
        next_r.active = speed_limit_pin_alloc &&
                        (cmd_mag > r.limit) && (spd_mag >= r.limit);
        // Sticky events, set wins over clear
        if (reg_wr && reg_addr == REG_STAT) begin
            next_r.status = r.status & ~reg_wdata[EV_N-1:0];
        end
        if (next_r.active && !r.active) begin
            next_r.status[EV_ON] = 1'b1;
        end
        if (!next_r.active && r.active) begin
            next_r.status[EV_OFF] = 1'b1;
        end
        next_r.irq = |(next_r.status & r.mask);
        next_r.rdata = '0;
        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: begin
                    next_r.pend_ext = reg_wdata[CTRL_EXT];
                    next_r.pend_ovs = reg_wdata[CTRL_OVS];
                    next_r.pend_lin = reg_wdata[CTRL_LINEAR];
                    if (reg_wdata[CTRL_RESTART]) begin
                        next_r.torque_control_option = reg_wdata[CTRL_EXT];
                        next_r.speed_limit_source_select =
                            reg_wdata[CTRL_OVS];
                        next_r.linear_motor = reg_wdata[CTRL_LINEAR];
                    end
                end
                REG_ROT: begin
                    if (reg_wdata[15:0] <= SET_MAX) begin
                        next_r.rotary_torque_speed_limit = reg_wdata[15:0];
                    end
                end
                REG_LIN: begin
                    if (reg_wdata[15:0] <= SET_MAX) begin
                        next_r.linear_force_speed_limit = reg_wdata[15:0];
                    end
                end
                REG_GAIN: begin
                    if (reg_wdata[31:16] == 16'h0000 &&
                        reg_wdata[15:0] >= GAIN_MIN &&
                        reg_wdata[15:0] <= GAIN_MAX) begin
                        next_r.speed_reference_input_gain = reg_wdata[15:0];
                    end
                end
                REG_MASK: begin
                    next_r.mask = reg_wdata[EV_N-1:0];
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: next_r.rdata = {28'h0000000, 1'b0,
                    r.pend_lin, r.pend_ovs, r.pend_ext};
                REG_ROT: next_r.rdata = {16'h0000,
                    r.rotary_torque_speed_limit};
                REG_LIN: next_r.rdata = {16'h0000,
                    r.linear_force_speed_limit};
                REG_GAIN: next_r.rdata = {16'h0000,
                    r.speed_reference_input_gain};
                REG_STAT: next_r.rdata = 32'(r.status);
                REG_MASK: next_r.rdata = 32'(r.mask);
                REG_LIMIT: next_r.rdata = 32'(r.limit);
                REG_ACTIVE: next_r.rdata = 32'(r.active);
                default: next_r.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.rotary_torque_speed_limit <= ROT_DEFAULT;
            r.linear_force_speed_limit <= LIN_DEFAULT;
            r.speed_reference_input_gain <= GAIN_DEF;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign speed_cmd_limited = r.cmd_out;
    assign speed_limit = r.limit;
    assign speed_limit_active_output = r.active;
    assign irq = r.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Internal limit bound
    a_limit_internal: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !r.torque_control_option |=> speed_limit <= $past(internal_lim))
        else $error("internal limit exceeded");
    a_limit_ext_min: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r.torque_control_option |=> speed_limit <= $past(r.ext_limit))
        else $error("external limit not applied");
    a_ceiling_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        1'b1 |=> speed_limit <= $past(ceiling))
        else $error("ceiling exceeded");
    a_rot_range: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r.rotary_torque_speed_limit <= SET_MAX)
        else $error("rotary setting out of range");
    a_lin_range: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r.linear_force_speed_limit <= SET_MAX)
        else $error("linear setting out of range");
    a_gain_range: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r.speed_reference_input_gain >= GAIN_MIN &&
        r.speed_reference_input_gain <= GAIN_MAX)
        else $error("gain out of range");
    a_clamp_sym: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        speed_cmd[W] && cmd_mag > r.limit |=>
        speed_cmd_limited == -$signed({1'b0, $past(r.limit)}))
        else $error("reverse clamp wrong");
    a_active_pin: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !speed_limit_pin_alloc |=> !speed_limit_active_output)
        else $error("active without pin");
    a_select_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !(reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_RESTART]) |=>
        $stable(r.torque_control_option))
        else $error("option changed without restart");
    a_src_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !(reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_RESTART]) |=>
        $stable(r.speed_limit_source_select))
        else $error("source changed without restart");
    a_vmag_pos: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        vref_in[VOLT_W-1] ? (W'(vmag + vref_in) == '0) :
        (vmag == W'(vref_in)))
        else $error("magnitude wrong");
    // Input equal to gain gives rated
    a_rated_gain: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        sc_done && $past(vmag, 2 * W + 2) ==
        $past(r.speed_reference_input_gain, 2 * W + 2) |->
        sc_quot == $past(rated_speed, 2 * W + 2))
        else $error("input equal to gain not rated speed");
    a_motor_sel: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r.linear_motor |-> setting == r.linear_force_speed_limit)
        else $error("motor type selection wrong");
endmodule // tmsl_limiter
`default_nettype wire

// >>> test/tmsl_host_model.sv
// Host controller model that drives the analog speed-limit sample
`default_nettype none
module tmsl_host_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [15:0] volt_set,
    output logic [15:0] vref_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Converter output follows the request one cycle later
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vref_in <= 16'h0000;
        end else begin
            vref_in <= volt_set;
        end
    end
endmodule // tmsl_host_model
`default_nettype wire

// >>> test/tmsl_limiter_tb_top.sv
// Self-checking bench for the torque-mode speed limiter
`default_nettype none
module tmsl_limiter_tb_top import tmsl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [15:0] motor_max_speed = 16'h0BB8;
    logic [15:0] overspeed_speed = 16'h0CE4;
    logic [15:0] rated_speed = 16'h07D0;
    logic [15:0] volt_set = 16'h0000;
    logic [15:0] vref_in;
    logic [15:0] speed_limit;
    logic signed [16:0] speed_cmd = 17'h00000;
    logic signed [16:0] motor_speed = 17'h00000;
    logic signed [16:0] speed_cmd_limited;
    logic speed_limit_pin_alloc = 1'b0;
    logic speed_limit_active_output;
    logic irq;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #2.5 sys_clk = ~sys_clk;

    tmsl_host_model tmsl_host_model_i (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .volt_set(volt_set),
        .vref_in(vref_in)
    );

    tmsl_limiter tmsl_limiter_i (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .motor_max_speed(motor_max_speed),
        .overspeed_speed(overspeed_speed),
        .rated_speed(rated_speed),
        .vref_in(vref_in),
        .speed_cmd(speed_cmd),
        .motor_speed(motor_speed),
        .speed_limit_pin_alloc(speed_limit_pin_alloc),
        .speed_cmd_limited(speed_cmd_limited),
        .speed_limit(speed_limit),
        .speed_limit_active_output(speed_limit_active_output),
        .irq(irq)
    );

    // ------------------------------------------------------------
    // Compare, access and closing tasks
    // ------------------------------------------------------------
    task automatic chk_val(input string name, input logic [31:0] exp,
                           input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp,
                           input logic got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %b, seen %b", name, exp, got);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_check(input string name, input logic [3:0] a,
                             input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk_val(name, exp, reg_rdata);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic check_limit(input logic [15:0] exp, input int n);
        settle(n);
        chk_val("speed_limit", {16'h0000, exp}, {16'h0000, speed_limit});
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        reg_check("rot", REG_ROT, 32'h00002710);
        reg_check("lin", REG_LIN, 32'h00002710);
        reg_check("gain", REG_GAIN, 32'h00000258);
        reg_check("ctrl", REG_CTRL, 32'h00000000);
        reg_check("unmapped", 4'h8, 32'h00000000);
        check_limit(16'h0BB8, 3);
        $display("test reset done");
        reg_write(REG_ROT, 32'h000005DC);
        check_limit(16'h05DC, 3);
        reg_write(REG_ROT, 32'h00002711);
        check_limit(16'h05DC, 3);
        reg_write(REG_ROT, 32'h00002710);
        reg_write(REG_CTRL, 32'h00000003);
        reg_check("ctrl", REG_CTRL, 32'h00000003);
        check_limit(16'h0BB8, 3);
        reg_write(REG_CTRL, 32'h0000000A);
        check_limit(16'h0CE4, 3);
        reg_write(REG_LIN, 32'h00000320);
        reg_write(REG_CTRL, 32'h0000000E);
        check_limit(16'h0320, 3);
        $display("test internal done");
        @(posedge sys_clk);
        volt_set <= 16'hFED4;
        reg_write(REG_CTRL, 32'h00000009);
        check_limit(16'h03E8, 80);
        @(posedge sys_clk);
        volt_set <= 16'h012C;
        check_limit(16'h03E8, 80);
        @(posedge sys_clk);
        volt_set <= 16'h0258;
        check_limit(16'h07D0, 80);
        reg_write(REG_GAIN, 32'h000004B0);
        check_limit(16'h03E8, 80);
        reg_write(REG_GAIN, 32'h00000095);
        reg_write(REG_GAIN, 32'h00000BB9);
        check_limit(16'h03E8, 80);
        reg_write(REG_GAIN, 32'h00000258);
        @(posedge sys_clk);
        volt_set <= 16'h04B0;
        check_limit(16'h0BB8, 80);
        @(posedge sys_clk);
        volt_set <= 16'h012C;
        check_limit(16'h03E8, 80);
        $display("test external done");
        reg_write(REG_STAT, 32'h00000003);
        reg_write(REG_MASK, 32'h00000001);
        @(posedge sys_clk);
        speed_cmd <= 17'h005DC;
        motor_speed <= 17'h004B0;
        speed_limit_pin_alloc <= 1'b1;
        settle(3);
        chk_val("cmd_lim", 32'h000003E8, 32'(speed_cmd_limited));
        chk_bit("active", 1'b1, speed_limit_active_output);
        chk_bit("irq", 1'b1, irq);
        reg_check("status", REG_STAT, 32'h00000001);
        reg_check("active_reg", REG_ACTIVE, 32'h00000001);
        reg_check("limit_reg", REG_LIMIT, 32'h000003E8);
        reg_write(REG_STAT, 32'h00000001);
        settle(2);
        chk_bit("irq", 1'b0, irq);
        @(posedge sys_clk);
        speed_cmd <= 17'h1FA24;
        motor_speed <= 17'h1FB50;
        settle(3);
        chk_val("cmd_lim", 32'hFFFFFC18, 32'(speed_cmd_limited));
        chk_bit("active", 1'b1, speed_limit_active_output);
        @(posedge sys_clk);
        speed_limit_pin_alloc <= 1'b0;
        settle(3);
        chk_bit("active", 1'b0, speed_limit_active_output);
        chk_val("cmd_lim", 32'hFFFFFC18, 32'(speed_cmd_limited));
        @(posedge sys_clk);
        speed_limit_pin_alloc <= 1'b1;
        speed_cmd <= 17'h001F4;
        settle(3);
        chk_val("cmd_lim", 32'h000001F4, 32'(speed_cmd_limited));
        chk_bit("active", 1'b0, speed_limit_active_output);
        chk_bit("irq", 1'b0, irq);
        reg_check("status", REG_STAT, 32'h00000002);
        $display("test clamp done");
        give_verdict();
    end
endmodule // tmsl_limiter_tb_top
`default_nettype wire
